// [rtl/pmp_fifo.sv]
// write request fifo between sequencer and flash array
`timescale 1ns/100ps
module pmp_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [rtl/pmp_frame_timer.sv]
// serial frame phase and cycle counters
`timescale 1ns/100ps
module pmp_frame_timer
    import pmp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic hold,
    output logic [1:0] phase_r,
    output logic [4:0] cycle_r
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= '0;
            cycle_r <= CYC_SYNC;
        end else if (!run) begin
            phase_r <= '0;
            cycle_r <= CYC_SYNC;
        end else if (!(hold && phase_r == '0 && cycle_r == CYC_SYNC)) begin
            phase_r <= phase_r + 1'b1;
            if (phase_r == 2'(CLKS_PER_CYCLE - 1)) begin
                cycle_r <= (cycle_r == 5'(CYCLES_PER_FRAME - 1)) ? CYC_SYNC : cycle_r + 1'b1;
            end
        end
    end
endmodule

// [rtl/pmp_pkg.sv]
// shared constants and types for the program memory programming logic
package pmp_pkg;
    // ==========================================================
    // widths and addresses
    localparam int ADDR_W = 13;
    localparam int DATA_W = 12;
    localparam int CMD_W = 4;
    localparam int LOW_W = 4;
    localparam int HIGH_W = 8;
    localparam logic [12:0] CFG_ADDR_SMALL = 13'h0fff;
    localparam logic [12:0] CFG_ADDR_LARGE = 13'h1fff;
    localparam logic [12:0] FIRST_ADDR = 13'h0000;
    localparam logic [11:0] WORD_ZERO = 12'h000;

    // ==========================================================
    // serial frame timing
    localparam int CLKS_PER_CYCLE = 4;
    localparam int CYCLES_PER_FRAME = 17;
    localparam logic [1:0] PH_SYNC = 2'h1;
    localparam logic [1:0] PH_SAMPLE = 2'h3;
    localparam logic [4:0] CYC_SYNC = 5'h00;
    localparam logic [4:0] CYC_CMD_LAST = 5'h04;
    localparam logic [4:0] CYC_DATA_FIRST = 5'h05;
    localparam logic [4:0] CYC_LAST = 5'h10;

    // ==========================================================
    // serial command codes
    localparam logic [3:0] SER_ERASE = 4'h0;
    localparam logic [3:0] SER_RD_IDENT = 4'h1;
    localparam logic [3:0] SER_RD_EXT = 4'h2;
    localparam logic [3:0] SER_PR_EXT = 4'h3;
    localparam logic [3:0] SER_LOAD = 4'h4;
    localparam logic [3:0] SER_PROGRAM = 4'h5;
    localparam logic [3:0] SER_READ = 4'h6;
    localparam logic [3:0] SER_INCR = 4'h7;

    // ==========================================================
    // parallel command codes and address step release count
    localparam logic [11:0] PAR_ERASE = 12'h010;
    localparam logic [11:0] PAR_RD_IDENT = 12'h001;
    localparam logic [11:0] PAR_RD_EXT = 12'h002;
    localparam logic [11:0] PAR_PR_EXT_LARGE = 12'h003;
    localparam logic [11:0] PAR_PR_EXT_SMALL = 12'h020;
    localparam logic [11:0] PAR_READ = 12'h004;
    localparam logic [11:0] PAR_PROGRAM = 12'h0ffe;
    localparam logic [1:0] STEP_RELEASE = 2'h2;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        PMP_SPACE_MAIN = 2'h0,
        PMP_SPACE_EXT = 2'h1,
        PMP_SPACE_IDENT = 2'h2
    } pmp_space_t;

    typedef enum logic [2:0] {
        PMP_OP_NONE, PMP_OP_ERASE, PMP_OP_RD_IDENT, PMP_OP_RD_EXT,
        PMP_OP_RD_MAIN, PMP_OP_PR_MAIN, PMP_OP_PR_EXT
    } pmp_op_t;

    typedef enum logic [1:0] {
        PMP_ST_IDLE = 2'b00,
        PMP_ST_SERIAL = 2'b01,
        PMP_ST_EXIT = 2'b11,
        PMP_ST_PARALLEL = 2'b10
    } pmp_state_t;

    typedef struct packed {
        pmp_space_t space;
        logic [12:0] addr;
        logic [11:0] data;
    } pmp_wr_t;
endpackage

// [rtl/pmp_top.sv]
// program memory programming sequencer, serial and parallel modes
// What this block does
// - load frame stores a word, program frames write it at pointer
// - serial line ignored during data cycles of program frames
// - serial entry points at primary config word
// - address order: config word, then 000h upward
// - increment at config word goes to 000h
// - each increment frame steps pointer by one, no write
// - exit after sync cycle, internal device reset pulsed
// - master clear rise enters parallel mode, latches command
// - low port holds four low bits, high port eight high bits
// - address step pulses from the third on advance pointer, strobe times operations
// - master clear to zero ends parallel mode with reset
// - new master clear rise latches a fresh command
// - decode 010h erase, 001h identity read, 002h extended read
// - decode 004h read data, FFEh program data
// - extended config write 003h large, 020h small variant
// - other parallel codes are reserved, no operation
// - erase clears whole memory, both config words
// - frame is 17 cycles of four clocks: sync, 4 cmd, 12 data
// - serial codes 0100 load, 0101 program, 0111 increment
// - erase active on decode, drops at strobe falling edge in parallel mode, at frame end in serial mode
`timescale 1ns/100ps
module pmp_top
    import pmp_pkg::*;
#(
    parameter bit LARGE = 1'b1,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic master_clear_pin_hv,
    input wire logic master_clear_pin_zero,
    input wire logic address_step_pin_hv,
    input wire logic address_step_pin,
    input wire logic operation_strobe_pin,
    input wire logic serial_program_line_in,
    output logic serial_program_line_out_r,
    output logic serial_program_line_oe_r,
    input wire logic [3:0] low_data_port_in,
    output logic [3:0] low_data_port_out_r,
    output logic low_data_port_oe_r,
    input wire logic [7:0] high_data_port_in,
    output logic [7:0] high_data_port_out_r,
    output logic high_data_port_oe_r,
    output logic [ADDR_W-1:0] mem_rd_addr_r,
    output pmp_space_t mem_rd_space_r,
    input wire logic [DATA_W-1:0] mem_rd_data,
    output pmp_wr_t mem_wr,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic mem_erase_r,
    output logic device_reset_r
);
    // ==========================================================
    // helpers
    localparam logic [12:0] CFG_ADDR = LARGE ? CFG_ADDR_LARGE : CFG_ADDR_SMALL;
    localparam logic [11:0] PAR_PR_EXT = LARGE ? PAR_PR_EXT_LARGE : PAR_PR_EXT_SMALL;

    function automatic logic [12:0] next_addr(input logic [12:0] a);
        // config word wraps to 000h
        next_addr = (a == CFG_ADDR) ? FIRST_ADDR : a + 1'b1;
    endfunction

    pmp_state_t state_r;
    logic [1:0] phase_r;
    logic [4:0] cycle_r;
    logic [3:0] cmd_sh_r;
    logic [11:0] data_sh_r;
    logic [11:0] rd_sh_r;
    logic [11:0] data_r;
    logic [11:0] par_cmd_r;
    logic [1:0] step_cnt_r;
    logic rb_phase_r;
    logic exit_req_r;
    logic master_clear_pin_hv_q;
    logic step_q;
    logic strobe_q;
    logic push_req_r;
    pmp_wr_t push_data_r;
    logic fifo_ready;
    pmp_op_t par_op;

    logic ser;
    logic par;
    logic sample;
    logic frame_end;
    logic sync_end;
    logic master_clear_pin_rise;
    logic step_rise;
    logic strobe_fall;
    logic par_live;
    logic [11:0] ser_word;
    logic [11:0] par_word;

    assign ser = (state_r == PMP_ST_SERIAL);
    assign par = (state_r == PMP_ST_PARALLEL);
    assign sample = ser && phase_r == PH_SAMPLE;
    assign frame_end = sample && cycle_r == CYC_LAST;
    assign sync_end = sample && cycle_r == CYC_SYNC;
    assign master_clear_pin_rise = master_clear_pin_hv && !master_clear_pin_hv_q;
    assign step_rise = address_step_pin && !step_q;
    assign strobe_fall = !operation_strobe_pin && strobe_q;
    assign par_live = par && step_cnt_r == STEP_RELEASE;
    assign ser_word = {data_sh_r[10:0], serial_program_line_in};
    assign par_word = {high_data_port_in, low_data_port_in};

    // ==========================================================
    // parallel command decode
    always_comb begin
        unique case (par_cmd_r)
            PAR_ERASE: par_op = PMP_OP_ERASE;
            PAR_RD_IDENT: par_op = PMP_OP_RD_IDENT;
            PAR_RD_EXT: par_op = PMP_OP_RD_EXT;
            PAR_READ: par_op = PMP_OP_RD_MAIN;
            PAR_PROGRAM: par_op = PMP_OP_PR_MAIN;
            PAR_PR_EXT: par_op = PMP_OP_PR_EXT;
            default: par_op = PMP_OP_NONE;
        endcase
    end

    // ==========================================================
    // frame timer and write fifo
    pmp_frame_timer u_timer (
        .clk(clk),
        .nrst(nrst),
        .run(ser),
        .hold(push_req_r && !fifo_ready),
        .phase_r(phase_r),
        .cycle_r(cycle_r)
    );

    pmp_fifo #(.WIDTH($bits(pmp_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_data(push_data_r),
        .in_valid(push_req_r),
        .in_ready(fifo_ready),
        .out_data(mem_wr),
        .out_valid(mem_wr_valid),
        .out_ready(mem_wr_ready)
    );

    // ==========================================================
    // mode state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= PMP_ST_IDLE;
            exit_req_r <= 1'b0;
            device_reset_r <= 1'b0;
            master_clear_pin_hv_q <= 1'b0;
            step_q <= 1'b0;
            strobe_q <= 1'b0;
            par_cmd_r <= WORD_ZERO;
        end else begin
            master_clear_pin_hv_q <= master_clear_pin_hv;
            step_q <= address_step_pin;
            strobe_q <= operation_strobe_pin;
            device_reset_r <= 1'b0;
            exit_req_r <= ser && (exit_req_r || !address_step_pin_hv);
            if (master_clear_pin_rise && (state_r == PMP_ST_IDLE || par)) begin
                par_cmd_r <= par_word;
            end
            unique case (state_r)
                PMP_ST_IDLE: begin
                    if (master_clear_pin_rise) begin
                        state_r <= PMP_ST_PARALLEL;
                    end else if (address_step_pin_hv) begin
                        state_r <= PMP_ST_SERIAL;
                    end
                end
                PMP_ST_SERIAL: begin
                    if (exit_req_r && sync_end) begin
                        state_r <= PMP_ST_EXIT;
                    end
                end
                PMP_ST_EXIT: begin
                    state_r <= PMP_ST_IDLE;
                    device_reset_r <= 1'b1;
                end
                PMP_ST_PARALLEL: begin
                    if (master_clear_pin_zero) begin
                        state_r <= PMP_ST_IDLE;
                        device_reset_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // serial shifters
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_sh_r <= '1;
            data_sh_r <= WORD_ZERO;
            data_r <= WORD_ZERO;
            rd_sh_r <= WORD_ZERO;
        end else if (sample) begin
            if (cycle_r != CYC_SYNC && cycle_r <= CYC_CMD_LAST) begin
                cmd_sh_r <= {cmd_sh_r[2:0], serial_program_line_in};
            end else if (cycle_r >= CYC_DATA_FIRST) begin
                rd_sh_r <= {rd_sh_r[10:0], 1'b0};
                if (cmd_sh_r == SER_LOAD) begin
                    data_sh_r <= ser_word;
                end
            end
            if (frame_end && cmd_sh_r == SER_LOAD) begin
                data_r <= ser_word;
            end
        end else if (ser && phase_r == '0 && cycle_r == CYC_DATA_FIRST) begin
            rd_sh_r <= mem_rd_data;
        end
    end

    // ==========================================================
    // serial line drive, open drain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serial_program_line_out_r <= 1'b0;
            serial_program_line_oe_r <= 1'b0;
        end else begin
            serial_program_line_out_r <= 1'b0;
            if (!ser) begin
                serial_program_line_oe_r <= 1'b0;
            end else if (phase_r == PH_SYNC - 1'b1) begin
                serial_program_line_oe_r <= (cycle_r != CYC_SYNC);
            end else if (phase_r == PH_SYNC || phase_r == PH_SYNC + 1'b1) begin
                serial_program_line_oe_r <= cycle_r >= CYC_DATA_FIRST && !rd_sh_r[11]
                    && (cmd_sh_r == SER_READ || cmd_sh_r == SER_RD_EXT
                    || cmd_sh_r == SER_RD_IDENT);
            end else begin
                serial_program_line_oe_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // address pointer and read space
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_rd_addr_r <= CFG_ADDR;
            mem_rd_space_r <= PMP_SPACE_MAIN;
            step_cnt_r <= '0;
        end else if (state_r == PMP_ST_IDLE || master_clear_pin_rise) begin
            mem_rd_addr_r <= CFG_ADDR;
            mem_rd_space_r <= PMP_SPACE_MAIN;
            step_cnt_r <= '0;
        end else if (ser) begin
            if (sample && cycle_r == CYC_CMD_LAST) begin
                unique case ({cmd_sh_r[2:0], serial_program_line_in})
                    SER_RD_EXT, SER_PR_EXT: mem_rd_space_r <= PMP_SPACE_EXT;
                    SER_RD_IDENT: mem_rd_space_r <= PMP_SPACE_IDENT;
                    default: mem_rd_space_r <= PMP_SPACE_MAIN;
                endcase
            end
            if (frame_end && cmd_sh_r == SER_INCR) begin
                mem_rd_addr_r <= next_addr(mem_rd_addr_r);
            end
        end else if (par && step_rise) begin
            if (step_cnt_r != STEP_RELEASE) begin
                step_cnt_r <= step_cnt_r + 1'b1;
                mem_rd_space_r <= (par_op == PMP_OP_RD_IDENT) ? PMP_SPACE_IDENT
                    : (par_op == PMP_OP_RD_EXT || par_op == PMP_OP_PR_EXT) ? PMP_SPACE_EXT
                    : PMP_SPACE_MAIN;
            end else begin
                mem_rd_addr_r <= next_addr(mem_rd_addr_r);
            end
        end
    end

    // ==========================================================
    // write requests and erase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            push_req_r <= 1'b0;
            push_data_r <= '0;
            mem_erase_r <= 1'b0;
            rb_phase_r <= 1'b0;
        end else begin
            if (push_req_r && fifo_ready) begin
                push_req_r <= 1'b0;
            end
            if (frame_end && (cmd_sh_r == SER_PROGRAM || cmd_sh_r == SER_PR_EXT)) begin
                push_req_r <= 1'b1;
                push_data_r <= '{mem_rd_space_r, mem_rd_addr_r, data_r};
            end
            if (step_rise || master_clear_pin_rise) begin
                rb_phase_r <= 1'b0;
            end else if (par_live && strobe_fall
                && (par_op == PMP_OP_PR_MAIN || par_op == PMP_OP_PR_EXT)) begin
                rb_phase_r <= 1'b1;
                if (!rb_phase_r) begin
                    push_req_r <= 1'b1;
                    push_data_r <= '{mem_rd_space_r, mem_rd_addr_r, par_word};
                end
            end
            if (ser) begin
                mem_erase_r <= (mem_erase_r && !frame_end)
                    || (sample && cycle_r == CYC_CMD_LAST
                    && {cmd_sh_r[2:0], serial_program_line_in} == SER_ERASE);
            end else if (master_clear_pin_rise) begin
                mem_erase_r <= (par_word == PAR_ERASE);
            end else if (strobe_fall || !par) begin
                mem_erase_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // parallel port drive
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_data_port_out_r <= '0;
            high_data_port_out_r <= '0;
            low_data_port_oe_r <= 1'b0;
            high_data_port_oe_r <= 1'b0;
        end else begin
            low_data_port_out_r <= mem_rd_data[LOW_W-1:0];
            high_data_port_out_r <= mem_rd_data[DATA_W-1:LOW_W];
            low_data_port_oe_r <= par_live && (par_op == PMP_OP_RD_MAIN
                || par_op == PMP_OP_RD_EXT || par_op == PMP_OP_RD_IDENT
                || (rb_phase_r && !operation_strobe_pin));
            high_data_port_oe_r <= par_live && (par_op == PMP_OP_RD_MAIN
                || par_op == PMP_OP_RD_EXT || par_op == PMP_OP_RD_IDENT
                || (rb_phase_r && !operation_strobe_pin));
        end
    end

    // ==========================================================
    // assertions
    property p_ser_ignore;
        @(posedge clk) disable iff (!nrst)
        (sample && cycle_r >= CYC_DATA_FIRST && cmd_sh_r == SER_PROGRAM)
            |=> $stable(data_sh_r) && $stable(data_r);
    endproperty
    a_ser_ignore: assert property (p_ser_ignore) else $error("data taken in program frame");

    property p_load;
        @(posedge clk) disable iff (!nrst)
        (frame_end && cmd_sh_r == SER_LOAD) |=> data_r == $past(ser_word);
    endproperty
    a_load: assert property (p_load) else $error("load word not held");

    property p_prog_push;
        @(posedge clk) disable iff (!nrst)
        (frame_end && cmd_sh_r == SER_PROGRAM)
            |=> push_req_r && push_data_r.data == $past(data_r)
                && push_data_r.addr == $past(mem_rd_addr_r);
    endproperty
    a_prog_push: assert property (p_prog_push) else $error("program frame lost");

    property p_entry;
        @(posedge clk) disable iff (!nrst)
        $rose(ser) |-> mem_rd_addr_r == CFG_ADDR;
    endproperty
    a_entry: assert property (p_entry) else $error("entry not at config word");

    property p_incr;
        @(posedge clk) disable iff (!nrst)
        (frame_end && cmd_sh_r == SER_INCR)
            |=> mem_rd_addr_r == next_addr($past(mem_rd_addr_r)) && !$rose(push_req_r);
    endproperty
    a_incr: assert property (p_incr) else $error("increment wrong");

    property p_cfg_wrap;
        @(posedge clk) disable iff (!nrst)
        (frame_end && cmd_sh_r == SER_INCR && mem_rd_addr_r == CFG_ADDR)
            |=> mem_rd_addr_r == FIRST_ADDR;
    endproperty
    a_cfg_wrap: assert property (p_cfg_wrap) else $error("no wrap to zero");

    property p_exit;
        @(posedge clk) disable iff (!nrst)
        (ser && exit_req_r && sync_end) |=> state_r == PMP_ST_EXIT ##1 device_reset_r;
    endproperty
    a_exit: assert property (p_exit) else $error("exit sequence wrong");

    property p_erase_drop;
        @(posedge clk) disable iff (!nrst)
        (par && mem_erase_r && strobe_fall && !master_clear_pin_rise) |=> !mem_erase_r;
    endproperty
    a_erase_drop: assert property (p_erase_drop) else $error("erase held past strobe");

    property p_reserved;
        @(posedge clk) disable iff (!nrst)
        (par && par_op == PMP_OP_NONE && !master_clear_pin_rise) |=> !$rose(push_req_r) && !$rose(mem_erase_r);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code acted");

    property p_master_clear_pin_exit;
        @(posedge clk) disable iff (!nrst)
        (par && master_clear_pin_zero) |=> state_r == PMP_ST_IDLE && device_reset_r;
    endproperty
    a_master_clear_pin_exit: assert property (p_master_clear_pin_exit) else $error("parallel not ended");

    c_ser_prog: cover property (@(posedge clk) disable iff (!nrst)
        frame_end && cmd_sh_r == SER_PROGRAM);
    c_ser_exit: cover property (@(posedge clk) disable iff (!nrst) state_r == PMP_ST_EXIT);
    c_par_erase: cover property (@(posedge clk) disable iff (!nrst)
        par && mem_erase_r ##1 !mem_erase_r);
    c_par_write: cover property (@(posedge clk) disable iff (!nrst)
        par_live && $rose(push_req_r));
endmodule

// [testbench/pmp_prog_model.sv]
// programmer unit model on the serial line
`timescale 1ns/100ps
module pmp_prog_model (
    input wire logic clk,
    input wire logic dev_pull,
    output logic line
);
    logic drv = 1'b0;
    logic bit_v = 1'b1;
    logic [11:0] rd_w = 12'h000;
    assign line = dev_pull ? 1'b0 : (drv ? bit_v : 1'b1);
    task automatic frame(input logic [15:0] w);
        repeat (2) @(posedge clk);
        for (int k = 0; k < 17; k++) begin
            drv <= (k > 0);
            bit_v <= (k > 0) ? w[16-k] : 1'b1;
            @(posedge clk);
            // read bits taken mid sample phase
            @(negedge clk);
            if (k > 4) rd_w <= {rd_w[10:0], line};
            if (k < 16) repeat (3) @(posedge clk);
        end
        @(posedge clk);
    endtask
endmodule

// [testbench/test_pmp_top.sv]
// self-checking bench for the programming sequencer
`timescale 1ns/100ps
module test_pmp_top;
    import pmp_pkg::*;
    logic clk = 0, nrst = 0, mc_hv = 0, mc_zero = 0, as_hv = 0, as_pin = 0, strobe = 1;
    logic [11:0] port_w = 12'h000;
    logic line, pull, erase, dres, wv, loe, hoe;
    logic [3:0] lo;
    logic [7:0] hi;
    logic [12:0] addr;
    pmp_space_t space;
    pmp_wr_t wr, last_wr;
    int bad_count = 0, samples_checked = 0, cyc = 0, wr_n = 0;
    pmp_top dut_u (.clk(clk), .nrst(nrst), .master_clear_pin_hv(mc_hv),
        .master_clear_pin_zero(mc_zero), .address_step_pin_hv(as_hv),
        .address_step_pin(as_pin), .operation_strobe_pin(strobe),
        .serial_program_line_in(line), .serial_program_line_out_r(),
        .serial_program_line_oe_r(pull), .low_data_port_in(port_w[3:0]),
        .low_data_port_out_r(lo), .low_data_port_oe_r(loe), .high_data_port_in(port_w[11:4]),
        .high_data_port_out_r(hi), .high_data_port_oe_r(hoe), .mem_rd_addr_r(addr),
        .mem_rd_space_r(space), .mem_rd_data(12'h5a5), .mem_wr(wr), .mem_wr_valid(wv),
        .mem_wr_ready(1'b1), .mem_erase_r(erase), .device_reset_r(dres));
    pmp_prog_model prog_u (.clk(clk), .dev_pull(pull), .line(line));
    initial forever #4 clk = ~clk;
    always @(negedge clk) begin
        cyc++;
        if (wv === 1'b1) begin
            wr_n++;
            last_wr = wr;
        end
        if (cyc == 30000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic chk(input logic [26:0] s, input logic [26:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wait_reset(input int lim);
        int n = 0;
        while (dres !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n < lim, 1);
        @(posedge clk);
    endtask
    task automatic serial_test();
        as_hv <= 1;
        @(posedge clk);
        prog_u.frame({SER_LOAD, 12'ha5c});
        chk(addr, CFG_ADDR_LARGE);
        prog_u.frame({SER_PROGRAM, 12'h0f0});
        prog_u.frame({SER_INCR, 12'h000});
        chk(last_wr, {PMP_SPACE_MAIN, CFG_ADDR_LARGE, 12'ha5c});
        prog_u.frame({SER_READ, 12'hfff});
        chk(prog_u.rd_w, 12'h5a5);
        prog_u.frame({SER_PROGRAM, 12'h333});
        prog_u.frame({SER_INCR, 12'h000});
        chk(last_wr, {PMP_SPACE_MAIN, FIRST_ADDR, 12'ha5c});
        prog_u.frame({SER_INCR, 12'h000});
        prog_u.frame({SER_PROGRAM, 12'h000});
        prog_u.frame(16'hffff);
        chk(last_wr.addr, 13'h0002);
        chk(wr_n, 3);
        as_hv <= 0;
        fork
            prog_u.frame(16'hffff);
            wait_reset(90);
        join
    endtask
    task automatic par_enter(input logic [11:0] c);
        mc_hv <= 0;
        mc_zero <= 0;
        port_w <= c;
        @(posedge clk) mc_hv <= 1;
        repeat (3) @(posedge clk);
    endtask
    task automatic par_exit();
        mc_hv <= 0;
        mc_zero <= 1;
        wait_reset(8);
    endtask
    task automatic strobe_op();
        @(posedge clk) strobe <= 0;
        repeat (3) @(posedge clk);
        strobe <= 1;
        repeat (4) @(posedge clk);
    endtask
    task automatic step();
        @(posedge clk) as_pin <= 1;
        @(posedge clk) as_pin <= 0;
    endtask
    task automatic par_write(input logic [11:0] c, input logic [11:0] d);
        par_enter(c);
        step();
        step();
        port_w <= d;
        strobe_op();
    endtask
    task automatic par_read(input logic [11:0] c, input pmp_space_t sp);
        par_enter(c);
        step();
        step();
        @(negedge clk) chk({space, addr}, {sp, CFG_ADDR_LARGE});
        @(negedge clk) chk({loe, hoe, hi, lo}, {2'b11, 12'h5a5});
        step();
        @(negedge clk) chk(addr, FIRST_ADDR);
        @(posedge clk);
        par_exit();
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        serial_test();
        par_read(PAR_RD_EXT, PMP_SPACE_EXT);
        par_enter(PAR_ERASE);
        @(negedge clk) chk(erase, 1);
        strobe_op();
        chk(erase, 0);
        par_exit();
        par_enter(12'h055);
        step();
        step();
        strobe_op();
        chk(erase, 0);
        chk(wr_n, 3);
        par_exit();
        par_read(PAR_READ, PMP_SPACE_MAIN);
        par_read(PAR_RD_IDENT, PMP_SPACE_IDENT);
        par_write(PAR_PROGRAM, 12'h3c7);
        chk(last_wr, {PMP_SPACE_MAIN, CFG_ADDR_LARGE, 12'h3c7});
        step();
        port_w <= 12'h124;
        strobe_op();
        chk(last_wr, {PMP_SPACE_MAIN, FIRST_ADDR, 12'h124});
        par_write(PAR_PR_EXT_LARGE, 12'h0e1);
        chk(last_wr.space, PMP_SPACE_EXT);
        par_exit();
        test_done();
    end
endmodule
